// ==== rtl/mid_pkg.sv ====
// Purpose: shared constants, types and decoder for the instruction decode core
// Assumes: one oscillator period per clk_sys edge
// Notes: the decoder is a function so core and datapath agree on one table
package mid_pkg;
  localparam int DW = 8;
  localparam int PCW = 13;
  localparam int OSC_PER_CYC = 4;
  localparam int D_BIT = 7;
  localparam logic [6:0] ADDR_TIMER_ZERO_COUNT = 7'h01;
  localparam logic [6:0] ADDR_PCL = 7'h02;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [13:0] W_IDLE = 14'h0000;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;

  typedef enum logic [5:0] {
    OP_ADD_F, OP_AND_F, OP_CLR_F, OP_CLR_A, OP_INV_F, OP_DEC_F, OP_DECSZ,
    OP_INC_F, OP_INCSZ, OP_OR_F, OP_MOV_F, OP_ST_A, OP_IDLE, OP_RLC, OP_RRC,
    OP_SUB_F, OP_SWAP, OP_XOR_F, OP_BCLR, OP_BSET, OP_TSTC, OP_TSTS, OP_ADD_L,
    OP_AND_L, OP_CALL, OP_KICK, OP_JUMP, OP_OR_L, OP_LD_L, OP_RETI, OP_RETL,
    OP_RET, OP_STBY, OP_SUB_L, OP_XOR_L, OP_BAD
  } mid_op_t;

  typedef enum logic [4:0] {
    PH_Q1 = 5'b00001,
    PH_Q2 = 5'b00010,
    PH_Q3 = 5'b00100,
    PH_Q4 = 5'b01000,
    PH_HALT = 5'b10000
  } mid_ph_t;

  // Fixed words come first so they win over the wider patterns below
  function automatic mid_op_t mid_decode(input logic [13:0] w);
    casez (w)
      14'b00_0000_0000_1000: return OP_RET;
      14'b00_0000_0000_1001: return OP_RETI;
      14'b00_0000_0110_0100: return OP_KICK;
      14'b00_0000_0110_0011: return OP_STBY;
      14'b00_0000_1???_????: return OP_ST_A;
      14'b00_0000_????_????: return OP_IDLE;
      14'b00_0001_0???_????: return OP_CLR_A;
      14'b00_0001_1???_????: return OP_CLR_F;
      14'b00_0010_????_????: return OP_SUB_F;
      14'b00_0011_????_????: return OP_DEC_F;
      14'b00_0100_????_????: return OP_OR_F;
      14'b00_0101_????_????: return OP_AND_F;
      14'b00_0110_????_????: return OP_XOR_F;
      14'b00_0111_????_????: return OP_ADD_F;
      14'b00_1000_????_????: return OP_MOV_F;
      14'b00_1001_????_????: return OP_INV_F;
      14'b00_1010_????_????: return OP_INC_F;
      14'b00_1011_????_????: return OP_DECSZ;
      14'b00_1100_????_????: return OP_RRC;
      14'b00_1101_????_????: return OP_RLC;
      14'b00_1110_????_????: return OP_SWAP;
      14'b00_1111_????_????: return OP_INCSZ;
      14'b01_00??_????_????: return OP_BCLR;
      14'b01_01??_????_????: return OP_BSET;
      14'b01_10??_????_????: return OP_TSTC;
      14'b01_11??_????_????: return OP_TSTS;
      14'b10_0???_????_????: return OP_CALL;
      14'b10_1???_????_????: return OP_JUMP;
      14'b11_00??_????_????: return OP_LD_L;
      14'b11_01??_????_????: return OP_RETL;
      14'b11_1000_????_????: return OP_OR_L;
      14'b11_1001_????_????: return OP_AND_L;
      14'b11_1010_????_????: return OP_XOR_L;
      14'b11_110?_????_????: return OP_SUB_L;
      14'b11_111?_????_????: return OP_ADD_L;
      default: return OP_BAD;
    endcase
  endfunction
endpackage

// ==== rtl/mid_ex_if.sv ====
// Purpose: carries operands and results between sequencer and datapath
// Assumes: datapath is purely combinational
// Notes: none
`timescale 1ns/1ps
interface mid_ex_if;
  import mid_pkg::*;
  logic [13:0] ir;
  logic [7:0] opnd;
  logic [7:0] acc;
  logic carry;
  mid_op_t op;
  logic [7:0] res;
  logic wr_f;
  logic wr_a;
  logic upd_z;
  logic upd_c;
  logic upd_dc;
  logic c_out;
  logic dc_out;
  logic skip;
  modport core (output ir, opnd, acc, carry,
                input op, res, wr_f, wr_a, upd_z, upd_c, upd_dc, c_out, dc_out, skip);
  modport alu (input ir, opnd, acc, carry,
               output op, res, wr_f, wr_a, upd_z, upd_c, upd_dc, c_out, dc_out, skip);
endinterface

// ==== rtl/mid_alu.sv ====
// Purpose: decodes the instruction word and computes result, routing and flags
// Assumes: operands held stable by the sequencer from Q3 until the result is stored in Q4
// Notes: flag values are produced here; the sequencer decides when to store them
`timescale 1ns/1ps
module mid_alu
  import mid_pkg::*;
(
  mid_ex_if.alu ex // Operands in, results out
);
  logic [7:0] k;
  logic [7:0] b;
  logic [7:0] bsel;
  logic [8:0] add9;
  logic [8:0] sub9;
  logic [4:0] add5;
  logic [4:0] sub5;
  logic d;

  always_comb
  begin
    ex.op = mid_decode(ex.ir); // see RL23, see RL24
    k = ex.ir[7:0];
    d = ex.ir[D_BIT];
    b = (ex.ir[13:12] == 2'b11) ? k : ex.opnd;
    bsel = 8'h01 << ex.ir[9:7];
    add9 = {1'b0, ex.acc} + {1'b0, b};
    add5 = {1'b0, ex.acc[3:0]} + {1'b0, b[3:0]};
    // Subtraction as b + ~acc + 1 so carry means no borrow
    sub9 = {1'b0, b} + {1'b0, ~ex.acc} + 9'h001;
    sub5 = {1'b0, b[3:0]} + {1'b0, ~ex.acc[3:0]} + 5'h01;
    ex.res = ex.opnd;
    ex.wr_f = d; // see RL20
    ex.wr_a = ~d;
    ex.upd_z = 1'b0;
    ex.upd_c = 1'b0;
    ex.upd_dc = 1'b0;
    ex.c_out = ex.carry;
    ex.dc_out = 1'b0;
    ex.skip = 1'b0;
    unique case (ex.op)
      OP_ADD_F, OP_ADD_L:
      begin
        ex.res = add9[7:0];
        ex.c_out = add9[8];
        ex.dc_out = add5[4];
        {ex.upd_z, ex.upd_c, ex.upd_dc} = 3'b111;
      end
      OP_SUB_F, OP_SUB_L:
      begin
        ex.res = sub9[7:0]; // see RL11
        ex.c_out = sub9[8];
        ex.dc_out = sub5[4];
        {ex.upd_z, ex.upd_c, ex.upd_dc} = 3'b111;
      end
      OP_AND_F, OP_AND_L:
      begin
        ex.res = ex.acc & b;
        ex.upd_z = 1'b1;
      end
      OP_OR_F, OP_OR_L:
      begin
        ex.res = ex.acc | b; // see RL4, see RL5
        ex.upd_z = 1'b1;
      end
      OP_XOR_F, OP_XOR_L:
      begin
        ex.res = ex.acc ^ b; // see RL4, see RL5
        ex.upd_z = 1'b1;
      end
      OP_CLR_F, OP_CLR_A:
      begin
        ex.res = 8'h00;
        ex.wr_f = (ex.op == OP_CLR_F);
        ex.wr_a = (ex.op == OP_CLR_A);
        ex.upd_z = 1'b1;
      end
      OP_INV_F:
      begin
        ex.res = ~ex.opnd;
        ex.upd_z = 1'b1;
      end
      OP_MOV_F:
        ex.upd_z = 1'b1;
      OP_DEC_F, OP_DECSZ:
      begin
        ex.res = ex.opnd - 8'h01; // see RL7
        ex.upd_z = (ex.op == OP_DEC_F);
        ex.skip = (ex.op == OP_DECSZ) && (ex.res == 8'h00);
      end
      OP_INC_F, OP_INCSZ:
      begin
        ex.res = ex.opnd + 8'h01; // see RL8
        ex.upd_z = (ex.op == OP_INC_F);
        ex.skip = (ex.op == OP_INCSZ) && (ex.res == 8'h00);
      end
      OP_RLC:
      begin
        ex.res = {ex.opnd[6:0], ex.carry}; // see RL6
        ex.c_out = ex.opnd[7];
        ex.upd_c = 1'b1;
      end
      OP_RRC:
      begin
        ex.res = {ex.carry, ex.opnd[7:1]}; // see RL6
        ex.c_out = ex.opnd[0];
        ex.upd_c = 1'b1;
      end
      OP_SWAP:
        ex.res = {ex.opnd[3:0], ex.opnd[7:4]};
      OP_ST_A:
      begin
        ex.res = ex.acc;
        ex.wr_f = 1'b1;
        ex.wr_a = 1'b0;
      end
      OP_BCLR, OP_BSET:
      begin
        // Whole byte written back, only the selected bit differs
        ex.res = (ex.op == OP_BSET) ? (ex.opnd | bsel) : (ex.opnd & ~bsel); // see RL3, see RL10
        ex.wr_f = 1'b1;
        ex.wr_a = 1'b0;
      end
      OP_TSTC, OP_TSTS:
      begin
        ex.wr_f = 1'b0;
        ex.wr_a = 1'b0;
        ex.skip = ((ex.opnd & bsel) != 8'h00) == (ex.op == OP_TSTS); // see RL9, see RL10
      end
      OP_LD_L, OP_RETL:
      begin
        ex.res = k; // see RL12
        ex.wr_f = 1'b0;
        ex.wr_a = 1'b1;
      end
      OP_IDLE, OP_CALL, OP_KICK, OP_JUMP, OP_RETI, OP_RET, OP_STBY, OP_BAD:
      begin
        ex.wr_f = 1'b0;
        ex.wr_a = 1'b0;
      end
    endcase
    if (ex.ir[13:12] == 2'b11 && ex.op != OP_RETL && ex.op != OP_LD_L && ex.op != OP_BAD)
    begin
      ex.wr_f = 1'b0;
      ex.wr_a = 1'b1;
    end
  end
endmodule

// ==== rtl/mid_core.sv ====
// Purpose: instruction sequencer and execute control for a 14-bit word core
// Assumes: register file answers file_rdata combinationally from file_addr
// Notes: stack storage and peripherals sit outside; only their strobes are here
// Overview of operation
// RL1 - Reading the counter low byte gives the current low byte of the counter.
// RL2 - Writes to the low byte load it and copy the high latch into high byte.
// RL3 - Bit clear and set read the whole byte and write it all back.
// RL4 - OR and XOR with a register route by destination, touch only zero flag.
// RL5 - OR and XOR with literal write the accumulator, touch only zero flag.
// RL6 - Rotates go through the carry by one place and change only carry.
// RL7 - Decrement sets zero flag; decrement-skip changes no flag, skips on zero.
// RL8 - Increment sets zero flag; increment-skip changes no flag, skips on zero.
// RL9 - Test bit skips the next word when the chosen bit is zero.
// RL10 - Test bit set skips on one; bit clear and set change no flags.
// RL11 - Both subtracts take the accumulator from the operand, updating three flags.
// RL12 - Return with literal loads the accumulator and returns in two cycles.
// RL13 - Fixed word 0x0008 returns from subroutine over two cycles.
// RL14 - Fixed word 0x0009 returns from interrupt over two cycles, flags untouched.
// RL15 - Fixed word 0x0064 restarts the watchdog and sets both power flags.
// RL16 - Fixed word 0x0063 sets the power flags then halts execution; the code sets time-out but clears power-down.
// RL17 - Port read-modify-write takes its operand from the pin levels.
// RL18 - Writing the timer clears the prescaler when assigned to that timer.
// RL19 - A counter change or true skip costs a second cycle run as idle.
// RL20 - Destination bit zero writes the accumulator, one writes the register.
// RL21 - One instruction cycle spans four oscillator periods.
// RL22 - Prefix 10 decodes as call or jump with an 11-bit target, two cycles.
// RL23 - Other opcodes decode by their fields and update only their own flags.
// RL24 - Don't-care opcode bits are ignored by the decoder.
`timescale 1ns/1ps
module mid_core
  import mid_pkg::*;
#(
  parameter int PORT_W = 8
)
(
  input wire logic clk_sys, // 100 MHz oscillator
  input wire logic rst, // Synchronous reset, high
  output logic [PCW-1:0] prog_addr, // Program memory address
  input wire logic [13:0] prog_word, // Program memory word
  output logic [6:0] file_addr, // Register file address
  input wire logic [DW-1:0] file_rdata, // Register file read data
  input wire logic file_is_port, // Addressed register is an I/O port
  input wire logic [PORT_W-1:0] pin_levels, // Raw port pin levels
  output logic [DW-1:0] file_wdata, // Register file write data
  output logic file_we, // Register file write strobe
  input wire logic [4:0] pc_high_latch, // Holding latch for counter high bits
  output logic stack_push, // Push return address
  output logic stack_pop, // Pop top of stack
  output logic [PCW-1:0] stack_ret_addr, // Address to push
  input wire logic [PCW-1:0] stack_top, // Top of stack
  output logic [DW-1:0] acc, // Accumulator
  output logic arith_overflow_bit, // Carry / no borrow
  output logic nibble_carry, // Carry out of bit 3
  output logic result_null_flag, // Result was zero
  output logic timeout_flag, // Watchdog time-out flag
  output logic sleep_flag, // Power-down flag
  input wire logic prescaler_assigned, // Prescaler serves the timer
  output logic prescaler_clr, // Clear prescaler strobe
  output logic wdt_restart, // Restart watchdog strobe
  output logic irq_enable_set, // Re-enable interrupts strobe
  output logic halted, // Core is in standby
  input wire logic wake // Leave standby
);
  mid_ph_t ph, next_ph;
  logic [13:0] ir, next_ir;
  logic [DW-1:0] opnd, next_opnd;
  logic [PCW-1:0] pc, next_pc;
  logic flush, next_flush;
  logic hold, next_hold;
  logic [6:0] next_file_addr;
  logic [DW-1:0] next_file_wdata;
  logic next_file_we;
  logic next_stack_push;
  logic next_stack_pop;
  logic [DW-1:0] next_acc;
  logic next_c;
  logic next_dc;
  logic next_z;
  logic next_to;
  logic next_pd;
  logic next_prescaler_clr;
  logic next_wdt_restart;
  logic next_irq_enable_set;
  logic next_halted;
  logic [PCW-1:0] next_ret_addr;
  logic [PORT_W-1:0] pin_s1;
  logic [PORT_W-1:0] pin_s2;
  logic [PORT_W-1:0] pin_s3;
  logic [PORT_W-1:0] pin_val, next_pin_val;
  logic [DW-1:0] pin_byte;

  mid_ex_if ex ();

  mid_alu u_alu (
    .ex (ex.alu)
  );

  assign ex.ir = ir;
  assign ex.opnd = opnd;
  assign ex.acc = acc;
  assign ex.carry = arith_overflow_bit;
  assign prog_addr = pc;
  assign pin_byte = DW'(pin_val);

  // Pin value moves only once the last two sync stages agree
  always_comb
  begin
    next_pin_val = (pin_s2 & ~(pin_s2 ^ pin_s3)) | (pin_val & (pin_s2 ^ pin_s3));
  end

  always_comb
  begin
    next_ph = ph;
    next_ir = ir;
    next_opnd = opnd;
    next_pc = pc;
    next_flush = flush;
    next_hold = hold;
    next_file_addr = file_addr;
    next_file_wdata = file_wdata;
    next_file_we = 1'b0;
    next_stack_push = 1'b0;
    next_stack_pop = 1'b0;
    next_acc = acc;
    next_c = arith_overflow_bit;
    next_dc = nibble_carry;
    next_z = result_null_flag;
    next_to = timeout_flag;
    next_pd = sleep_flag;
    next_prescaler_clr = 1'b0;
    next_wdt_restart = 1'b0;
    next_irq_enable_set = 1'b0;
    next_halted = halted;
    next_ret_addr = stack_ret_addr;
    unique case (ph)
      PH_Q1:
      begin
        // Four phases make one instruction cycle
        next_ph = PH_Q2; // see RL21
        // A flushed cycle runs the fetched word as an idle op
        next_ir = flush ? W_IDLE : prog_word; // see RL19
        next_file_addr = prog_word[6:0];
        // After a branch the word at the target must not be passed over
        if (!hold)
        begin
          next_pc = pc + 13'h0001;
        end
        next_flush = 1'b0;
        next_hold = 1'b0;
      end
      PH_Q2:
      begin
        next_ph = PH_Q3;
        if (file_addr == ADDR_PCL)
        begin
          next_opnd = pc[7:0]; // see RL1, see RL2
        end
        else if (file_is_port)
        begin
          // Read-modify-write on a port sees the pins, not the latch
          next_opnd = pin_byte; // see RL17
        end
        else
        begin
          next_opnd = file_rdata; // see RL3
        end
      end
      PH_Q3:
        next_ph = PH_Q4;
      PH_Q4:
      begin
        next_ph = PH_Q1;
        if (ex.wr_a)
        begin
          next_acc = ex.res; // see RL20
        end
        if (ex.wr_f)
        begin
          next_file_wdata = ex.res; // see RL20
          next_file_we = 1'b1;
          if (file_addr == ADDR_PCL)
          begin
            next_pc = {pc_high_latch, ex.res}; // see RL1, see RL2
            next_flush = 1'b1; // see RL19
            next_hold = 1'b1;
          end
          if (file_addr == ADDR_TIMER_ZERO_COUNT && prescaler_assigned)
          begin
            next_prescaler_clr = 1'b1; // see RL18
          end
        end
        if (ex.upd_z)
        begin
          next_z = (ex.res == 8'h00); // see RL4, see RL5, see RL7, see RL8
        end
        if (ex.upd_c)
        begin
          next_c = ex.c_out; // see RL6, see RL11
        end
        if (ex.upd_dc)
        begin
          next_dc = ex.dc_out; // see RL11
        end
        if (ex.skip)
        begin
          next_flush = 1'b1; // see RL7, see RL8, see RL9, see RL10, see RL19
        end
        unique case (ex.op)
          OP_CALL, OP_JUMP:
          begin
            next_stack_push = (ex.op == OP_CALL); // see RL22
            next_ret_addr = pc;
            next_pc = {pc_high_latch[4:3], ir[10:0]}; // see RL22
            next_flush = 1'b1;
            next_hold = 1'b1;
          end
          OP_RET, OP_RETL, OP_RETI:
          begin
            next_stack_pop = 1'b1; // see RL12, see RL13, see RL14
            next_pc = stack_top;
            next_flush = 1'b1; // see RL19
            next_hold = 1'b1;
            next_irq_enable_set = (ex.op == OP_RETI); // see RL14
          end
          OP_KICK:
          begin
            next_wdt_restart = 1'b1; // see RL15
            next_to = 1'b1;
            next_pd = 1'b1;
          end
          OP_STBY:
          begin
            // Standby also restarts the watchdog so it can time the sleep
            next_wdt_restart = 1'b1; // see RL16
            next_to = 1'b1;
            next_pd = 1'b0;
            next_ph = PH_HALT;
            next_halted = 1'b1;
          end
          default:
          begin
            next_pc = next_pc;
          end
        endcase
      end
      PH_HALT:
      begin
        if (wake)
        begin
          next_ph = PH_Q1;
          next_halted = 1'b0;
        end
      end
      default:
      begin
        next_ph = PH_Q1;
        next_halted = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    pin_s1 <= pin_levels;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
    if (rst)
    begin
      ph <= PH_Q1;
      ir <= W_IDLE;
      opnd <= 8'h00;
      pc <= PC_RST;
      flush <= 1'b0;
      hold <= 1'b0;
      file_addr <= 7'h00;
      file_wdata <= 8'h00;
      file_we <= 1'b0;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      acc <= ACC_RST;
      arith_overflow_bit <= 1'b0;
      nibble_carry <= 1'b0;
      result_null_flag <= 1'b0;
      timeout_flag <= TO_RST;
      sleep_flag <= PD_RST;
      prescaler_clr <= 1'b0;
      wdt_restart <= 1'b0;
      irq_enable_set <= 1'b0;
      halted <= 1'b0;
      stack_ret_addr <= PC_RST;
      pin_val <= '0;
    end
    else
    begin
      ph <= next_ph;
      ir <= next_ir;
      opnd <= next_opnd;
      pc <= next_pc;
      flush <= next_flush;
      hold <= next_hold;
      file_addr <= next_file_addr;
      file_wdata <= next_file_wdata;
      file_we <= next_file_we;
      stack_push <= next_stack_push;
      stack_pop <= next_stack_pop;
      acc <= next_acc;
      arith_overflow_bit <= next_c;
      nibble_carry <= next_dc;
      result_null_flag <= next_z;
      timeout_flag <= next_to;
      sleep_flag <= next_pd;
      prescaler_clr <= next_prescaler_clr;
      wdt_restart <= next_wdt_restart;
      irq_enable_set <= next_irq_enable_set;
      halted <= next_halted;
      stack_ret_addr <= next_ret_addr;
      pin_val <= next_pin_val;
    end
  end
endmodule

// ==== testbench/mid_core_monitor.sv ====
// Purpose: port-level assertions for the instruction decode core
// Assumes: bound onto mid_core, one clock domain, synchronous reset
// Notes: results and strobes land right after the fourth edge of a cycle
`timescale 1ns/1ps
module mid_core_monitor
  import mid_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset, high
  input wire logic [mid_pkg::PCW-1:0] prog_addr, // Counter
  input wire logic [6:0] file_addr, // Register address
  input wire logic [mid_pkg::DW-1:0] file_wdata, // Write data
  input wire logic file_we, // Write strobe
  input wire logic [4:0] pc_high_latch, // High latch
  input wire logic stack_push, // Push strobe
  input wire logic stack_pop, // Pop strobe
  input wire logic [mid_pkg::PCW-1:0] stack_top, // Top of stack
  input wire logic [mid_pkg::DW-1:0] acc, // Accumulator
  input wire logic result_null_flag, // Zero flag
  input wire logic timeout_flag, // Time-out flag
  input wire logic sleep_flag, // Power-down flag
  input wire logic prescaler_assigned, // Prescaler owner
  input wire logic prescaler_clr, // Prescaler clear
  input wire logic wdt_restart, // Watchdog restart
  input wire logic irq_enable_set, // Interrupt re-enable
  input wire logic halted, // Standby
  input wire logic wake // Wake request
);
  default clocking mon_cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  write_spacing_a: assert property (file_we |=> !file_we [*3])
    else $error("write strobes closer than one instruction cycle");
  pcl_load_a: assert property (file_we && file_addr == ADDR_PCL
    |-> prog_addr == {$past(pc_high_latch), file_wdata}) else $error("counter not loaded from low byte write");
  timer_clear_a: assert property (prescaler_clr ==
    (file_we && file_addr == ADDR_TIMER_ZERO_COUNT && $past(prescaler_assigned)))
    else $error("prescaler clear does not match timer write");
  standby_entry_a: assert property ($rose(halted) |-> wdt_restart && timeout_flag && !sleep_flag)
    else $error("standby entry flags wrong");
  standby_hold_a: assert property (halted && !wake |=> halted && $stable(prog_addr))
    else $error("core ran while in standby");
  kick_flags_a: assert property (wdt_restart && !halted |-> timeout_flag && sleep_flag)
    else $error("watchdog kick flags wrong");
  return_load_a: assert property (stack_pop |-> prog_addr == $past(stack_top))
    else $error("return did not load top of stack");
  irq_return_a: assert property (irq_enable_set |-> stack_pop && $stable(result_null_flag))
    else $error("interrupt return malformed");
  flush_idle_a: assert property (stack_push |=> (!file_we && $stable(acc)) [*4])
    else $error("flushed cycle had an effect");

  cover property (stack_push);
  cover property ($rose(halted));
  cover property (prescaler_clr);
endmodule

// ==== testbench/mid_mem_model.sv ====
// Purpose: program memory, register file and return stack facing mid_core
// Assumes: reads answer combinationally from the address
// Notes: the port register is plain storage; only its read is redirected
`timescale 1ns/1ps
module mid_mem_model
  import mid_pkg::*;
#(
  parameter logic [6:0] PORT_ADDR = 7'h06
)
(
  input wire logic clk_sys, // Clock
  input wire logic [mid_pkg::PCW-1:0] prog_addr, // Fetch address
  output logic [13:0] prog_word, // Fetched word
  input wire logic [6:0] file_addr, // Register address
  output logic [mid_pkg::DW-1:0] file_rdata, // Read data
  output logic file_is_port, // Address is the port
  input wire logic [mid_pkg::DW-1:0] file_wdata, // Write data
  input wire logic file_we, // Write strobe
  input wire logic stack_push, // Push strobe
  input wire logic stack_pop, // Pop strobe
  input wire logic [mid_pkg::PCW-1:0] stack_ret_addr, // Pushed address
  output logic [mid_pkg::PCW-1:0] stack_top // Top of stack
);
  logic [13:0] prog [64];
  logic [DW-1:0] regs [128];
  logic [PCW-1:0] stk [8];
  logic [2:0] sp = 3'h0;
  // Only 64 words: high counter bits alias, so tests may use any high latch
  assign prog_word = prog[prog_addr[5:0]];
  assign file_rdata = regs[file_addr];
  assign file_is_port = (file_addr == PORT_ADDR);
  assign stack_top = stk[sp - 3'h1];
  always @(posedge clk_sys)
  begin
    if (file_we)
      regs[file_addr] <= file_wdata;
    if (stack_push)
    begin
      stk[sp] <= stack_ret_addr;
      sp <= sp + 3'h1;
    end
    else if (stack_pop)
      sp <= sp - 3'h1;
  end
endmodule

// ==== testbench/test_mcu14_instr_decode.sv ====
// Purpose: self-checking bench for mid_core running short programs
// Assumes: mid_mem_model answers fetches and register reads
// Notes: every register write is matched in order against a queue of notes
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_mcu14_instr_decode;
  import mid_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] pin_levels = 8'h00;
  logic [4:0] pc_high_latch = 5'h00;
  logic prescaler_assigned = 1'b1;
  logic wake = 1'b0;
  logic [12:0] prog_addr, stack_ret_addr, stack_top;
  logic [13:0] prog_word, w;
  logic [6:0] file_addr;
  logic [7:0] file_rdata, file_wdata, acc, a, b, s, r, r2, k, p;
  logic file_is_port, file_we, stack_push, stack_pop, arith_overflow_bit, nibble_carry, result_null_flag;
  logic timeout_flag, sleep_flag, prescaler_clr, wdt_restart, irq_enable_set, halted;
  logic [14:0] exp_q[$];
  logic [14:0] e;
  logic [2:0] bi;
  logic [4:0] h;
  int num_errors = 0;
  int num_checks = 0;
  int n;

  mid_core mid_core_inst (.clk_sys, .rst, .prog_addr, .prog_word, .file_addr, .file_rdata, .file_is_port,
    .pin_levels, .file_wdata, .file_we, .pc_high_latch, .stack_push, .stack_pop, .stack_ret_addr,
    .stack_top, .acc, .arith_overflow_bit, .nibble_carry, .result_null_flag, .timeout_flag, .sleep_flag,
    .prescaler_assigned, .prescaler_clr, .wdt_restart, .irq_enable_set, .halted, .wake);
  mid_mem_model mid_mem_model_inst (.clk_sys, .prog_addr, .prog_word, .file_addr, .file_rdata, .file_is_port,
    .file_wdata, .file_we, .stack_push, .stack_pop, .stack_ret_addr, .stack_top);

  always #5 clk_sys = ~clk_sys;

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic note(input logic [6:0] ad, input logic [7:0] d);
    exp_q.push_back({ad, d});
  endtask

  task automatic put(input int i, input logic [13:0] wd);
    mid_mem_model_inst.prog[i] = wd;
  endtask

  // Loading while the core runs could execute half-written programs
  task automatic clear_prog();
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 64; i++) mid_mem_model_inst.prog[i] = W_IDLE;
    for (int i = 0; i < 128; i++) mid_mem_model_inst.regs[i] = 8'h00;
  endtask

  task automatic start();
    int c;
    c = 0;
    rst <= 1'b0;
    while (exp_q.size() != 0 && c < 400)
    begin
      @(posedge clk_sys);
      c++;
    end
    `CHK(exp_q.size(), 0)
    exp_q.delete();
    repeat (8) @(posedge clk_sys);
    n++;
    $display("test %0d done", n);
  endtask

  always @(posedge clk_sys)
    if (!rst && file_we === 1'b1)
    begin
      e = (exp_q.size() == 0) ? 15'h7fff : exp_q.pop_front();
      `CHK({file_addr, file_wdata}, e)
    end

  initial
  begin
    #100000;
    num_errors++;
    summarize();
  end

  initial
  begin
    void'($urandom(91585));
    n = 0;
    repeat (18) @(posedge clk_sys);
    a = 8'($urandom);
    b = 8'($urandom);
    clear_prog();
    put(0, 14'h3300 | a);
    put(1, 14'h00a0);
    note(7'h20, a);
    put(2, 14'h3800 | b);
    put(3, 14'h00a1);
    note(7'h21, a | b);
    put(4, 14'h06a0);
    note(7'h20, (a | b) ^ a);
    put(5, 14'h3d00 | b);
    put(6, 14'h00a2);
    s = b - (a | b);
    note(7'h22, s);
    put(7, 14'h3a00 | s);
    put(8, 14'h00a3);
    note(7'h23, 8'h00);
    put(9, 14'h2809);
    start();
    `CHK(result_null_flag, 1'b1)
    `CHK(arith_overflow_bit, b >= (a | b))
    `CHK(nibble_carry, b[3:0] >= (a[3:0] | b[3:0]))

    r = 8'($urandom);
    bi = 3'($urandom);
    w = {4'h0, bi, 7'h30};
    clear_prog();
    mid_mem_model_inst.regs[7'h30] = r;
    mid_mem_model_inst.regs[7'h31] = 8'h01;
    mid_mem_model_inst.regs[7'h32] = 8'hff;
    r2 = {r[6:0], 1'b0};
    put(0, 14'h0db0);
    note(7'h30, r2);
    put(1, 14'h0c30);
    put(2, 14'h00b3);
    note(7'h33, {r[7], r2[7:1]});
    put(3, 14'h0bb1);
    note(7'h31, 8'h00);
    put(4, 14'h3055);
    put(5, 14'h0fb2);
    note(7'h32, 8'h00);
    put(6, 14'h00b4);
    put(7, 14'h0ab1);
    note(7'h31, 8'h01);
    put(8, 14'h1400 | w);
    note(7'h30, r2 | (8'h01 << bi));
    put(9, 14'h1800 | w);
    put(10, 14'h1000 | w);
    note(7'h30, r2 & ~(8'h01 << bi));
    put(11, 14'h1800 | w);
    put(12, 14'h00b6);
    put(13, 14'h1c00 | w);
    put(14, 14'h00b5);
    note(7'h35, {r[7], r2[7:1]});
    put(15, 14'h2011);
    put(16, 14'h2810);
    put(17, 14'h0008);
    start();
    `CHK(arith_overflow_bit, 1'b0)
    `CHK(result_null_flag, 1'b0)

    p = 8'($urandom);
    h = 5'($urandom);
    k = 8'($urandom);
    prescaler_assigned <= 1'($urandom);
    clear_prog();
    pin_levels <= p;
    pc_high_latch <= h;
    mid_mem_model_inst.regs[7'h06] = ~p;
    put(0, 14'h200a);
    put(1, 14'h00c0);
    note(7'h40, k);
    put(2, 14'h0064);
    put(3, 14'h0886);
    note(7'h06, p);
    put(4, 14'h0181);
    note(7'h01, 8'h00);
    put(5, 14'h0802);
    put(6, 14'h00c1);
    note(7'h41, 8'h06);
    put(7, 14'h300c);
    put(8, 14'h0082);
    note(7'h02, 8'h0c);
    put(9, 14'h00cf);
    put(10, 14'h3400 | k);
    put(12, 14'h0063);
    put(13, 14'h200f);
    put(14, 14'h280e);
    put(15, 14'h0009);
    start();
    for (int c = 0; c < 100 && halted !== 1'b1; c++) @(posedge clk_sys);
    `CHK(halted, 1'b1)
    `CHK(sleep_flag, 1'b0)
    `CHK(timeout_flag, 1'b1)
    repeat (5) @(posedge clk_sys);
    wake <= 1'b1;
    repeat (2) @(posedge clk_sys);
    wake <= 1'b0;
    repeat (40) @(posedge clk_sys);
    `CHK(halted, 1'b0)
    `CHK(prog_addr[12:1], {h[4:3], 10'h007})
    n++;
    $display("test %0d done", n);
    summarize();
  end
endmodule

bind mid_core mid_core_monitor mid_core_monitor_inst (.clk_sys, .rst, .prog_addr, .file_addr, .file_wdata,
  .file_we, .pc_high_latch, .stack_push, .stack_pop, .stack_top, .acc, .result_null_flag, .timeout_flag,
  .sleep_flag, .prescaler_assigned, .prescaler_clr, .wdt_restart, .irq_enable_set, .halted, .wake);
